// ==== design/vcocal_pkg.sv ====
// Constants for the oscillator tuning and converter calibration control block
//
// Behaviour
// R01: Settle wait after each trim change grows with tuning_settle_time; resets to 4.
// R02: Tuning starts when conv_pll_hold is written to zero with vco_tuning_enable set.
// R03: Engine searches oscillator_trim on its own to centre the oscillator.
// R04: Host changes tuning control only while conv_pll_hold is one.
// R05: vco_tuning_done is one after tuning ends, or when tuning was skipped.
// R06: Host never writes oscillator_trim while tuning is in progress.
// R07: adc_cal_run high runs calibration; low holds it in reset; resets to one.
// R08: Clearing adc_cal_run also resets processing and serial link clock dividers.
// R09: Host clears adc_cal_run before changing marked settings, then sets it again.
// R10: Host sets adc_cal_run before serial_link_enable and clears in reverse order.
// R11: Bit 3 enables background offset calibration, only with background calibration on.
// R12: Bit 2 enables foreground offset calibration, only with foreground calibration on.
// R13: Bit 1 enables continuous background calibration; zero by default.
// R14: A run always resets calibration values, then foreground runs if selected.
// R15: Host writes reset values back into reserved fields.
// R16: Host sets conv_pll_hold before PLL programming and clears it afterwards.
// R17: oscillator_trim is seven bits, set by the engine, readable and writable.
package vcocal_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_TRIM = 8'h59;
  localparam logic [7:0] ADDR_HOLD = 8'h5c;
  localparam logic [7:0] ADDR_TUNE_CTRL = 8'h5d;
  localparam logic [7:0] ADDR_TUNE_STAT = 8'h5e;
  localparam logic [7:0] ADDR_CAL_RUN = 8'h61;
  localparam logic [7:0] ADDR_CAL_SEL = 8'h62;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_TRIM = 8'h00;
  localparam logic [7:0] RST_HOLD = 8'h00;
  localparam logic [7:0] RST_TUNE_CTRL = 8'h40;
  localparam logic [7:0] RST_CAL_RUN = 8'h01;
  localparam logic [7:0] RST_CAL_SEL = 8'h01;
  // ==========================================================
  // Field positions
  localparam int BIT_HOLD = 0;
  localparam int BIT_TUNE_EN = 0;
  localparam int SETTLE_LSB = 4;
  localparam int SETTLE_MSB = 6;
  localparam int BIT_TUNE_DONE = 0;
  localparam int BIT_CAL_RUN = 0;
  localparam int BIT_FG_RUN = 0;
  localparam int BIT_BG_EN = 1;
  localparam int BIT_FG_OS = 2;
  localparam int BIT_BG_OS = 3;
  localparam int TRIM_W = 7;
  // ==========================================================
  // Timing: one settle unit, the wait per step is (field + 1) units
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETTLE_UNIT_NS = 1000;
  localparam int SETTLE_UNIT_CYC = (SETTLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  // ==========================================================
  // States
  typedef enum logic [1:0] {T_IDLE, T_WAIT} vcocal_tune_e;
  typedef enum logic [1:0] {C_HELD, C_CLEAR, C_FG, C_RUN} vcocal_cal_e;
endpackage : vcocal_pkg

// ==== design/vcocal_tuner.sv ====
// Oscillator trim search engine with per-step settle wait
module vcocal_tuner (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Control
  input wire logic start_i,
  input wire logic enable_i,
  input wire logic abort_i,
  input wire logic [2:0] settle_sel_i,
  input wire logic vco_fast_i,
  // Host trim access
  input wire logic trim_wr_i,
  input wire logic [6:0] trim_wdata_i,
  // Status
  output logic [6:0] trim_o,
  output logic busy_o,
  output logic done_o
);
  vcocal_pkg::vcocal_tune_e state, next_state;
  logic [6:0] next_trim;
  logic [2:0] bitpos, next_bitpos;
  logic [15:0] cnt, next_cnt;
  logic next_done;

  function automatic logic [15:0] settle_cycles(input logic [2:0] sel);
    settle_cycles = 16'((int'(sel) + 1) * vcocal_pkg::SETTLE_UNIT_CYC); // R01
  endfunction

  // ==========================================================
  // Successive approximation, MSB first
  always_comb begin
    next_state = state;
    next_trim = trim_o;
    next_bitpos = bitpos;
    next_cnt = cnt;
    next_done = done_o;
    if (abort_i) begin
      next_state = vcocal_pkg::T_IDLE;
      next_done = 1'b0;
      // Trim is normally programmed while the PLL is held
      if (trim_wr_i) begin
        next_trim = trim_wdata_i; // R17
      end
    end else begin
      case (state)
        vcocal_pkg::T_IDLE: begin
          if (start_i && enable_i) begin // R02
            next_state = vcocal_pkg::T_WAIT;
            next_trim = 7'h40;
            next_bitpos = 3'h6;
            next_cnt = settle_cycles(settle_sel_i);
            next_done = 1'b0;
          end else if (start_i) begin
            next_done = 1'b1; // R05
          end else if (trim_wr_i) begin
            // Host writes land only while the engine is idle or aborted
            next_trim = trim_wdata_i; // R17
          end
        end
        vcocal_pkg::T_WAIT: begin
          if (cnt != 16'h0000) begin
            next_cnt = cnt - 16'h0001;
          end else begin
            if (vco_fast_i) begin
              next_trim[bitpos] = 1'b0; // R03
            end
            if (bitpos == 3'h0) begin
              next_state = vcocal_pkg::T_IDLE;
              next_done = 1'b1; // R05
            end else begin
              next_bitpos = bitpos - 3'h1;
              next_trim[bitpos - 3'h1] = 1'b1;
              next_cnt = settle_cycles(settle_sel_i); // R01
            end
          end
        end
        default: next_state = vcocal_pkg::T_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state <= vcocal_pkg::T_IDLE;
      trim_o <= vcocal_pkg::RST_TRIM[6:0];
      bitpos <= 3'h0;
      cnt <= 16'h0000;
      done_o <= 1'b0;
    end else begin
      state <= next_state;
      trim_o <= next_trim;
      bitpos <= next_bitpos;
      cnt <= next_cnt;
      done_o <= next_done;
    end
  end

  assign busy_o = (state == vcocal_pkg::T_WAIT);

  // ==========================================================
  // Checks
  settle_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R01
    (busy_o && !abort_i && cnt != 16'h0000) |=> $stable(trim_o) || abort_i)
    else $error("Trim moved during settle wait");
  done_when_finished_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R05
    (busy_o && !abort_i && cnt == 16'h0000 && bitpos == 3'h0) |=> (done_o && !busy_o))
    else $error("Done not raised after last step");
endmodule // vcocal_tuner

// ==== design/vcocal_ctrl.sv ====
// Register bank and sequencing for oscillator tuning and converter calibration
module vcocal_ctrl (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Oscillator tuning
  input wire logic vco_fast_i,
  output logic [6:0] trim_o,
  output logic pll_hold_o,
  output logic tuning_busy_o,
  output logic tuning_done_o,
  // Converter calibration
  input wire logic fg_cal_done_i,
  output logic cal_hold_o,
  output logic dsp_div_reset_o,
  output logic cal_values_clear_o,
  output logic fg_cal_active_o,
  output logic fg_offset_cal_o,
  output logic bg_cal_enable_o,
  output logic bg_offset_cal_o
);
  logic [7:0] hold_reg, next_hold_reg;
  logic [7:0] tune_ctrl, next_tune_ctrl;
  logic [7:0] cal_run, next_cal_run;
  logic [7:0] cal_sel, next_cal_sel;
  logic [7:0] next_rdata;
  logic [1:0] fast_sync;
  logic tune_start, trim_wr;
  vcocal_pkg::vcocal_cal_e cal_state, next_cal_state;

  function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] target,
                                  input logic wr);
    wr_hit = wr && (addr == target);
  endfunction

  // ==========================================================
  // Register writes
  always_comb begin
    next_hold_reg = hold_reg;
    next_tune_ctrl = tune_ctrl;
    next_cal_run = cal_run;
    next_cal_sel = cal_sel;
    if (wr_hit(reg_addr_i, vcocal_pkg::ADDR_HOLD, reg_wr_i)) begin
      next_hold_reg = reg_wdata_i;
    end
    if (wr_hit(reg_addr_i, vcocal_pkg::ADDR_TUNE_CTRL, reg_wr_i)) begin
      // Taken as written; changing it outside hold is the host's hazard
      next_tune_ctrl = reg_wdata_i;
    end
    if (wr_hit(reg_addr_i, vcocal_pkg::ADDR_CAL_RUN, reg_wr_i)) begin
      next_cal_run = reg_wdata_i; // R07
    end
    if (wr_hit(reg_addr_i, vcocal_pkg::ADDR_CAL_SEL, reg_wr_i)) begin
      next_cal_sel = reg_wdata_i;
    end
  end

  // Start only on a one-to-zero write of the hold bit
  assign tune_start = wr_hit(reg_addr_i, vcocal_pkg::ADDR_HOLD, reg_wr_i)
                      && !reg_wdata_i[vcocal_pkg::BIT_HOLD]
                      && hold_reg[vcocal_pkg::BIT_HOLD]; // R02
  assign trim_wr = wr_hit(reg_addr_i, vcocal_pkg::ADDR_TRIM, reg_wr_i);

  // ==========================================================
  // Register reads, one cycle latency
  always_comb begin
    case (reg_addr_i)
      vcocal_pkg::ADDR_TRIM: next_rdata = {1'b0, trim_o}; // R17
      vcocal_pkg::ADDR_HOLD: next_rdata = hold_reg;
      vcocal_pkg::ADDR_TUNE_CTRL: next_rdata = tune_ctrl;
      vcocal_pkg::ADDR_TUNE_STAT: next_rdata = {7'h00, tuning_done_o}; // R05
      vcocal_pkg::ADDR_CAL_RUN: next_rdata = cal_run;
      vcocal_pkg::ADDR_CAL_SEL: next_rdata = cal_sel;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      hold_reg <= vcocal_pkg::RST_HOLD;
      tune_ctrl <= vcocal_pkg::RST_TUNE_CTRL; // R01
      cal_run <= vcocal_pkg::RST_CAL_RUN; // R07
      cal_sel <= vcocal_pkg::RST_CAL_SEL; // R14
      reg_rdata_o <= 8'h00;
      fast_sync <= 2'b00;
    end else begin
      hold_reg <= next_hold_reg;
      tune_ctrl <= next_tune_ctrl;
      cal_run <= next_cal_run;
      cal_sel <= next_cal_sel;
      reg_rdata_o <= next_rdata;
      // Comparator comes from the analog side
      fast_sync <= {fast_sync[0], vco_fast_i};
    end
  end

  assign pll_hold_o = hold_reg[vcocal_pkg::BIT_HOLD];

  // ==========================================================
  // Tuning engine
  vcocal_tuner u_tuner (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .start_i(tune_start),
    .enable_i(tune_ctrl[vcocal_pkg::BIT_TUNE_EN]),
    // Hold bit is still set in the start cycle; letting it abort would swallow the start
    .abort_i(pll_hold_o && !tune_start),
    .settle_sel_i(tune_ctrl[vcocal_pkg::SETTLE_MSB:vcocal_pkg::SETTLE_LSB]),
    .vco_fast_i(fast_sync[1]),
    .trim_wr_i(trim_wr),
    .trim_wdata_i(reg_wdata_i[6:0]),
    .trim_o(trim_o),
    .busy_o(tuning_busy_o),
    .done_o(tuning_done_o)
  );

  // ==========================================================
  // Calibration sequencer
  always_comb begin
    next_cal_state = cal_state;
    if (!cal_run[vcocal_pkg::BIT_CAL_RUN]) begin
      next_cal_state = vcocal_pkg::C_HELD; // R07
    end else begin
      case (cal_state)
        vcocal_pkg::C_HELD: next_cal_state = vcocal_pkg::C_CLEAR;
        vcocal_pkg::C_CLEAR: begin
          if (cal_sel[vcocal_pkg::BIT_FG_RUN]) begin // R14
            next_cal_state = vcocal_pkg::C_FG;
          end else begin
            next_cal_state = vcocal_pkg::C_RUN;
          end
        end
        vcocal_pkg::C_FG: begin
          if (fg_cal_done_i) begin
            next_cal_state = vcocal_pkg::C_RUN;
          end
        end
        vcocal_pkg::C_RUN: next_cal_state = vcocal_pkg::C_RUN;
        default: next_cal_state = vcocal_pkg::C_HELD;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cal_state <= vcocal_pkg::C_HELD;
    end else begin
      cal_state <= next_cal_state;
    end
  end

  assign cal_hold_o = (cal_state == vcocal_pkg::C_HELD); // R07
  // Dividers restart with the calibration so the link sees a clean phase
  assign dsp_div_reset_o = (cal_state == vcocal_pkg::C_HELD); // R08
  assign cal_values_clear_o = (cal_state == vcocal_pkg::C_CLEAR); // R14
  assign fg_cal_active_o = (cal_state == vcocal_pkg::C_FG);
  assign fg_offset_cal_o = fg_cal_active_o && cal_sel[vcocal_pkg::BIT_FG_OS]
                           && cal_sel[vcocal_pkg::BIT_FG_RUN]; // R12
  assign bg_cal_enable_o = (cal_state == vcocal_pkg::C_RUN)
                           && cal_sel[vcocal_pkg::BIT_BG_EN]; // R13
  assign bg_offset_cal_o = bg_cal_enable_o && cal_sel[vcocal_pkg::BIT_BG_OS]; // R11

  // ==========================================================
  // Checks
  sequence run_rise_s;
    !cal_hold_o ##0 $past(cal_hold_o);
  endsequence
  sequence clear_then_fg_s;
    cal_values_clear_o ##1 fg_cal_active_o;
  endsequence

  tune_start_busy_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R02
    (tune_start && tune_ctrl[vcocal_pkg::BIT_TUNE_EN]) |=> tuning_busy_o)
    else $error("Tuning did not start on hold release");
  no_start_in_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R02
    (pll_hold_o && !tune_start) |=> !tuning_busy_o)
    else $error("Tuning ran while hold set");
  skip_sets_done_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R05
    (tune_start && !tune_ctrl[vcocal_pkg::BIT_TUNE_EN]) |=> tuning_done_o)
    else $error("Skipped tuning not reported done");
  run_low_holds_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R07
    !cal_run[vcocal_pkg::BIT_CAL_RUN] |=> (cal_hold_o && dsp_div_reset_o))
    else $error("Calibration not held when run cleared");
  clear_first_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R14
    run_rise_s |-> (cal_values_clear_o && !fg_cal_active_o))
    else $error("Values not cleared first");
  run_starts_clear_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R14
    (cal_hold_o && cal_run[vcocal_pkg::BIT_CAL_RUN]) |=> cal_values_clear_o)
    else $error("Run did not begin with a clear");
  fg_follows_clear_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R14
    (cal_values_clear_o && cal_run[vcocal_pkg::BIT_CAL_RUN]
     && cal_sel[vcocal_pkg::BIT_FG_RUN]) |-> clear_then_fg_s or ##1 cal_hold_o)
    else $error("Foreground skipped though selected");
  bg_offset_gate_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R11
    bg_offset_cal_o |-> (bg_cal_enable_o && cal_sel[vcocal_pkg::BIT_BG_EN]))
    else $error("Background offset without background");
  fg_offset_gate_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R12
    fg_offset_cal_o |-> (fg_cal_active_o && cal_sel[vcocal_pkg::BIT_FG_RUN]))
    else $error("Foreground offset without foreground");
endmodule // vcocal_ctrl

// ==== verification/tb_vco_and_adc_calibration_control.sv ====
// Self-checking bench for the tuning and calibration control register bank
module tb_vco_and_adc_calibration_control;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Design signals
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic vco_fast_i = 1'b0;
  logic [6:0] trim_o;
  logic pll_hold_o, tuning_busy_o, tuning_done_o;
  logic fg_cal_done_i = 1'b0;
  logic cal_hold_o, dsp_div_reset_o, cal_values_clear_o;
  logic fg_cal_active_o, fg_offset_cal_o, bg_cal_enable_o, bg_offset_cal_o;
  // ==========================================================
  // Bench state
  int fail_count = 0;
  int checks = 0;
  int seed = 32'h96bb;
  int mdl[int];
  logic [7:0] tgt = 8'h00;
  int n0, n1;
  logic [7:0] v;

  always #25 clk_sys_i = ~clk_sys_i;

  vcocal_ctrl DUT (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .vco_fast_i(vco_fast_i), .trim_o(trim_o),
    .pll_hold_o(pll_hold_o), .tuning_busy_o(tuning_busy_o),
    .tuning_done_o(tuning_done_o), .fg_cal_done_i(fg_cal_done_i),
    .cal_hold_o(cal_hold_o), .dsp_div_reset_o(dsp_div_reset_o),
    .cal_values_clear_o(cal_values_clear_o), .fg_cal_active_o(fg_cal_active_o),
    .fg_offset_cal_o(fg_offset_cal_o), .bg_cal_enable_o(bg_cal_enable_o),
    .bg_offset_cal_o(bg_offset_cal_o)
  );

  // Oscillator stand-in: above centre whenever trim exceeds the target
  always @(negedge clk_sys_i) vco_fast_i <= ({1'b0, trim_o} > tgt);

  task automatic conclude();
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask

  // Status register is not writable, so the model skips it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
    if (mdl.exists(a) && a != 8'h5e) mdl[a] = (a == 8'h59) ? (d & 8'h7f) : d;
    if (a == 8'h5c && d[0]) mdl[8'h5e] = 0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    @(negedge clk_sys_i);
    chk8(reg_rdata_o, mdl.exists(a) ? 8'(mdl[a]) : 8'h00);
  endtask

  // Full search of seven bits, most significant first
  function automatic int srch(input int t);
    int r;
    r = 0;
    for (int b = 6; b >= 0; b--) begin
      r = r | (1 << b);
      if (r > t) r = r & ~(1 << b);
    end
    return r;
  endfunction

  task automatic tune(input logic [7:0] ctrl, output int n);
    wr(8'h5c, 8'h01);
    chk1(pll_hold_o, 1'b1);
    wr(8'h5d, ctrl);
    wr(8'h5c, 8'h00);
    @(posedge clk_sys_i) #1;
    chk1(ctrl[0] ? tuning_busy_o : tuning_done_o, 1'b1);
    n = 0;
    while (tuning_done_o !== 1'b1 && n < 2000) begin
      @(posedge clk_sys_i) #1;
      n++;
    end
    mdl[8'h5e] = 1;
    if (ctrl[0]) mdl[8'h59] = srch(int'(tgt));
    chk8({1'b0, trim_o}, 8'(mdl[8'h59]));
    rd(8'h5e);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    conclude();
  end

  initial begin
    mdl[8'h59] = 0; mdl[8'h5c] = 0; mdl[8'h5d] = 8'h40;
    mdl[8'h5e] = 0; mdl[8'h61] = 1; mdl[8'h62] = 1;
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk1(dsp_div_reset_o, 1'b1);
    srst_i = 1'b0;
    @(posedge clk_sys_i) #1;
    chk1(cal_values_clear_o, 1'b1);
    @(posedge clk_sys_i) #1;
    chk1(fg_cal_active_o, 1'b1);
    chk1(cal_hold_o, 1'b0);
    // ==========================================================
    // Reset values, read-only status and an unmapped place
    rd(8'h59); rd(8'h5c); rd(8'h5d);
    rd(8'h61); rd(8'h62);
    wr(8'h5e, 8'($random(seed)));
    rd(8'h5e);
    wr(8'h63, 8'($random(seed)) | 8'h01);
    rd(8'h63);
    // ==========================================================
    // Calibration options while foreground runs, then in run state
    wr(8'h62, 8'h05);
    chk1(fg_offset_cal_o, 1'b1);
    chk1(bg_cal_enable_o, 1'b0);
    @(negedge clk_sys_i) fg_cal_done_i = 1'b1;
    @(negedge clk_sys_i) fg_cal_done_i = 1'b0;
    chk1(fg_cal_active_o, 1'b0);
    for (int k = 0; k < 16; k++) begin
      v = 8'(k);
      wr(8'h62, v);
      chk1(bg_cal_enable_o, v[1]);
      chk1(bg_offset_cal_o, v[1] & v[3]);
      chk1(fg_offset_cal_o, 1'b0);
    end
    // ==========================================================
    // Hold and re-run with foreground skipped
    wr(8'h62, 8'h02);
    wr(8'h61, 8'h00);
    // Run bit lands on the write edge, the sequencer follows one edge later
    @(posedge clk_sys_i) #1;
    chk1(cal_hold_o, 1'b1);
    chk1(dsp_div_reset_o, 1'b1);
    chk1(bg_cal_enable_o, 1'b0);
    rd(8'h61);
    wr(8'h61, 8'h01);
    chk1(cal_hold_o, 1'b1);
    @(posedge clk_sys_i) #1;
    chk1(cal_values_clear_o, 1'b1);
    @(posedge clk_sys_i) #1;
    chk1(fg_cal_active_o, 1'b0);
    chk1(bg_cal_enable_o, 1'b1);
    chk1(dsp_div_reset_o, 1'b0);
    // ==========================================================
    // Oscillator tuning: skipped, then two settle settings
    tune(8'h40, n0);
    tgt = 8'($random(seed)) & 8'h7f;
    tune(8'h01, n0);
    rd(8'h59);
    tgt = 8'($random(seed)) & 8'h7f;
    tune(8'h11, n1);
    chk8(8'(n1 - n0), 8'h8c);
    chk1(n0 >= 140 && n0 <= 150, 1'b1);
    wr(8'h5c, 8'h01);
    @(posedge clk_sys_i) #1;
    chk1(tuning_done_o, 1'b0);
    rd(8'h5e);
    wr(8'h59, 8'ha5);
    chk8({1'b0, trim_o}, 8'h25);
    rd(8'h59);
    conclude();
  end
endmodule // tb_vco_and_adc_calibration_control
